// *** hw/flash_host_pkg.sv ***
// Package of command codes, status bit positions, bus types and timing
package flash_host_pkg;

    // ------------------------------------------------------------
    // Command codes and status bits
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam int SEQ_READY_BIT = 7;
    localparam int ERASE_SUSP_BIT = 6;
    localparam int ERASE_FAIL_BIT = 5;
    localparam int PROG_FAIL_BIT = 4;
    localparam int SUPPLY_LOW_BIT = 3;
    localparam int PROG_SUSP_BIT = 2;
    localparam int LOCKED_BIT = 1;

    // ------------------------------------------------------------
    // Bus timing (40 MHz reference)
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int STROBE_NS = 100;
    localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        OP_PROGRAM = 3'h0,
        OP_ERASE = 3'h1,
        OP_SUSPEND = 3'h2,
        OP_RESUME = 3'h3,
        OP_CLEAR = 3'h4,
        OP_READ_ARRAY = 3'h5,
        OP_READ = 3'h6,
        OP_STATUS = 3'h7
    } op_type;

    typedef struct packed
    {
        op_type op;
        logic [21:0] addr;
        logic [15:0] data;
    } req_type;

    typedef struct packed
    {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
    } strobe_type;

endpackage : flash_host_pkg

// *** hw/flash_bus_cycle.sv ***
// One asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
module flash_bus_cycle
    import flash_host_pkg::*;
#(
    parameter int HOLD_CYC = STROBE_CYC
)
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic write_i,
    input wire logic [15:0] dq_sync_i,
    output logic busy_o,
    output logic done_o,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic dq_oe_o,
    output logic [15:0] rdata_o
);

    initial
    begin
        if (HOLD_CYC < 4 || HOLD_CYC > 255)
            $error("HOLD_CYC out of range");
    end

    logic [7:0] cnt_reg;
    logic active_reg;
    logic write_reg;
    logic last;
    // Data sampled one extra cycle early so the two-stage sync has settled
    assign last = active_reg && (cnt_reg == 8'(HOLD_CYC));
    assign busy_o = active_reg;
    assign ce_n_o = ~active_reg || last;
    assign oe_n_o = ~active_reg || write_reg || last;
    assign we_n_o = ~active_reg || ~write_reg || last;
    assign dq_oe_o = active_reg && write_reg;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= 8'h00;
            active_reg <= 1'b0;
            write_reg <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
        end
        else
        begin
            done_o <= last;
            if (start_i && !active_reg)
            begin
                active_reg <= 1'b1;
                write_reg <= write_i;
                cnt_reg <= 8'h00;
            end
            else if (last)
                active_reg <= 1'b0;
            else if (active_reg)
                cnt_reg <= cnt_reg + 8'h01;
            if (active_reg && !write_reg && cnt_reg == 8'(HOLD_CYC - 1))
                rdata_o <= dq_sync_i;
        end
    end

endmodule : flash_bus_cycle

// *** hw/flash_host_ctrl.sv ***
// Host controller that programs, erases and polls a NOR flash
`timescale 1ns/1ps
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int HOLD_CYC = STROBE_CYC,
    parameter int POLL_MAX = 65535
)
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire req_type req_i,
    input wire logic abort_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic [7:0] status_o,
    output logic err_locked_o,
    output logic err_supply_o,
    output logic err_program_o,
    output logic err_erase_o,
    output logic err_sequence_o,
    output logic err_timeout_o,
    output logic suspended_o,
    output logic [21:0] addr_o,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    input wire logic [15:0] dq_i,
    output strobe_type strobe_o
);

    initial
    begin
        if (POLL_MAX < 1 || POLL_MAX > 65535)
            $error("POLL_MAX out of range");
    end

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic [15:0] dq_meta_reg;
    logic [15:0] dq_sync_reg;

    always_ff @(posedge ref_clk_i)
    begin
        dq_meta_reg <= dq_i;
        dq_sync_reg <= dq_meta_reg;
    end

    // ------------------------------------------------------------
    // Sequence engine
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h0,
        ST_CMD1 = 4'h1,
        ST_CMD2 = 4'h3,
        ST_RSTAT = 4'h2,
        ST_POLL = 4'h6,
        ST_CHECK = 4'h7,
        ST_FIN = 4'h5,
        ST_DONE = 4'h4,
        ST_RESET = 4'hC
    } state_type;

    state_type state_reg;
    state_type state_next;
    req_type req_reg;
    logic [15:0] poll_reg;
    logic [7:0] status_reg;
    logic reset_pin_reg;
    logic [7:0] rst_cnt_reg;

    logic cyc_start;
    logic cyc_write;
    logic cyc_busy;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic cyc_ce_n;
    logic cyc_oe_n;
    logic cyc_we_n;
    logic cyc_dq_oe;
    logic [15:0] wdata;
    logic two_writes;
    logic needs_poll;
    logic ready_bit;
    logic poll_expired;

    flash_bus_cycle #(
        .HOLD_CYC(HOLD_CYC)
    ) u_cycle (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .start_i(cyc_start),
        .write_i(cyc_write),
        .dq_sync_i(dq_sync_reg),
        .busy_o(cyc_busy),
        .done_o(cyc_done),
        .ce_n_o(cyc_ce_n),
        .oe_n_o(cyc_oe_n),
        .we_n_o(cyc_we_n),
        .dq_oe_o(cyc_dq_oe),
        .rdata_o(cyc_rdata)
    );

    assign two_writes = (req_reg.op == OP_PROGRAM) ||
        (req_reg.op == OP_ERASE);
    // Suspend waits for ready too, so the suspend bits are valid
    assign needs_poll = two_writes || (req_reg.op == OP_SUSPEND) ||
        (req_reg.op == OP_RESUME);
    assign ready_bit = cyc_rdata[SEQ_READY_BIT];
    assign poll_expired = (state_reg == ST_POLL) && !cyc_done &&
        (poll_reg == 16'(POLL_MAX));
    assign req_ready_o = (state_reg == ST_IDLE) && !rst_i;
    assign cyc_start = !cyc_busy && !cyc_done &&
        (state_reg == ST_CMD1 || state_reg == ST_CMD2 ||
         state_reg == ST_RSTAT || state_reg == ST_POLL ||
         state_reg == ST_FIN);
    assign cyc_write = (state_reg != ST_POLL) &&
        !(state_reg == ST_CMD1 && req_reg.op == OP_READ);

    always_comb
    begin
        wdata = 16'h0000;
        unique case (req_reg.op)
            OP_PROGRAM: wdata = {8'h00, CMD_PROG_SETUP};
            OP_ERASE: wdata = {8'h00, CMD_ERASE_SETUP};
            OP_SUSPEND: wdata = {8'h00, CMD_SUSPEND};
            OP_RESUME: wdata = {8'h00, CMD_CONFIRM};
            OP_CLEAR: wdata = {8'h00, CMD_CLEAR_STATUS};
            OP_READ_ARRAY: wdata = {8'h00, CMD_READ_ARRAY};
            OP_READ: wdata = 16'h0000;
            OP_STATUS: wdata = {8'h00, CMD_READ_STATUS};
        endcase
        if (state_reg == ST_CMD2)
            wdata = (req_reg.op == OP_PROGRAM) ? req_reg.data
                : {8'h00, CMD_CONFIRM};
        if (state_reg == ST_RSTAT)
            wdata = {8'h00, CMD_READ_STATUS};
        if (state_reg == ST_FIN)
            wdata = {8'h00, CMD_READ_ARRAY};
    end

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (req_valid_i)
                    state_next = ST_CMD1;
            ST_CMD1:
                if (cyc_done)
                begin
                    if (two_writes)
                        state_next = ST_CMD2;
                    else if (needs_poll)
                        state_next = ST_RSTAT;
                    else if (req_reg.op == OP_STATUS)
                        state_next = ST_POLL;
                    else
                        state_next = ST_DONE;
                end
            ST_CMD2:
                if (cyc_done)
                    state_next = ST_POLL;
            ST_RSTAT:
                if (cyc_done)
                    state_next = ST_POLL;
            ST_POLL:
                if (cyc_done)
                begin
                    if (req_reg.op == OP_STATUS)
                        state_next = ST_DONE;
                    else if (ready_bit)
                        state_next = ST_CHECK;
                end
                else if (poll_expired)
                    state_next = ST_RESET;
            ST_CHECK:
                state_next = two_writes ? ST_FIN : ST_DONE;
            ST_FIN:
                if (cyc_done)
                    state_next = ST_DONE;
            ST_DONE:
                state_next = ST_IDLE;
            ST_RESET:
                if (rst_cnt_reg == 8'(HOLD_CYC))
                    state_next = ST_DONE;
        endcase
        if (abort_i && state_reg != ST_IDLE && state_reg != ST_RESET)
            state_next = ST_RESET;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ST_IDLE;
            req_reg <= '0;
            poll_reg <= 16'h0000;
            status_reg <= 8'h00;
            rst_cnt_reg <= 8'h00;
            reset_pin_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && req_valid_i)
                req_reg <= req_i;
            // Each poll is a fresh CE/OE pulse, which refreshes status
            if (state_reg == ST_POLL && cyc_done)
            begin
                status_reg <= cyc_rdata[7:0];
                poll_reg <= poll_reg + 16'h0001;
            end
            else if (state_reg != ST_POLL)
                poll_reg <= 16'h0000;
            reset_pin_reg <= (state_next == ST_RESET);
            rst_cnt_reg <= (state_reg == ST_RESET) ?
                rst_cnt_reg + 8'h01 : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            addr_o <= 22'h000000;
            dq_o <= 16'h0000;
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
            err_timeout_o <= 1'b0;
        end
        else
        begin
            addr_o <= req_reg.addr;
            dq_o <= wdata;
            done_o <= (state_reg == ST_DONE);
            if (state_reg == ST_CMD1 && cyc_done && !cyc_write)
                rdata_o <= cyc_rdata;
            if (poll_expired)
                err_timeout_o <= 1'b1;
            else if (state_reg == ST_IDLE && req_valid_i)
                err_timeout_o <= 1'b0;
        end
    end

    // Error bits only mean anything once the ready bit is seen
    assign status_o = status_reg;
    assign err_locked_o = status_reg[SEQ_READY_BIT] &&
        status_reg[LOCKED_BIT];
    assign err_supply_o = status_reg[SEQ_READY_BIT] &&
        status_reg[SUPPLY_LOW_BIT];
    assign err_sequence_o = status_reg[SEQ_READY_BIT] &&
        status_reg[ERASE_FAIL_BIT] && status_reg[PROG_FAIL_BIT];
    assign err_erase_o = status_reg[SEQ_READY_BIT] &&
        status_reg[ERASE_FAIL_BIT] && !status_reg[PROG_FAIL_BIT];
    assign err_program_o = status_reg[SEQ_READY_BIT] &&
        status_reg[PROG_FAIL_BIT] && !status_reg[ERASE_FAIL_BIT];
    assign suspended_o = status_reg[SEQ_READY_BIT] &&
        (status_reg[PROG_SUSP_BIT] || status_reg[ERASE_SUSP_BIT]);
    assign dq_oe_o = cyc_dq_oe && !reset_pin_reg;
    assign strobe_o.ce_n = cyc_ce_n || reset_pin_reg;
    assign strobe_o.oe_n = cyc_oe_n || reset_pin_reg;
    assign strobe_o.we_n = cyc_we_n || reset_pin_reg;
    assign strobe_o.rst_n = !reset_pin_reg;

endmodule : flash_host_ctrl

// *** verification/flash_host_ctrl_properties.sv ***
// Checker of strobe decode, strobe timing and status flag relations
`timescale 1ns/1ps
module flash_host_ctrl_properties
    import flash_host_pkg::*;
#(
    parameter int HOLD_CYC = 4
)
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic done_o,
    input wire logic [7:0] status_o,
    input wire logic err_locked_o,
    input wire logic err_program_o,
    input wire logic err_erase_o,
    input wire logic err_sequence_o,
    input wire logic suspended_o,
    input wire logic dq_oe_o,
    input wire strobe_type strobe_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    int low_cnt;
    // ----------------------------------------
    // Helper: length of the chip-select window
    // ----------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || strobe_o.ce_n)
            low_cnt <= 0;
        else
            low_cnt <= low_cnt + 1;
    end
    a_strobe_width: assert property ($rose(strobe_o.ce_n)
        && strobe_o.rst_n |-> low_cnt >= HOLD_CYC)
        else $error("strobe too short");
    a_write_decode: assert property (!strobe_o.we_n
        |-> !strobe_o.ce_n && strobe_o.oe_n && dq_oe_o)
        else $error("bad write strobes");
    a_read_decode: assert property (!strobe_o.oe_n
        |-> !strobe_o.ce_n && strobe_o.we_n && !dq_oe_o)
        else $error("bad read strobes");
    a_reset_pulse: assert property ($fell(strobe_o.rst_n)
        |-> !strobe_o.rst_n [*4]) else $error("reset pulse short");
    a_done_single: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    a_err_ready: assert property ((err_locked_o || err_program_o
        || err_erase_o) |-> status_o[7]) else $error("error while busy");
    a_err_seq: assert property (err_sequence_o
        == (status_o[7] && status_o[5] && status_o[4]))
        else $error("sequence flag wrong");
    a_err_erase: assert property (err_erase_o
        |-> status_o[5] && !status_o[4]) else $error("erase flag wrong");
    a_susp_flag: assert property (suspended_o
        == (status_o[7] && (status_o[2] || status_o[6])))
        else $error("suspend flag wrong");
    a_lock_flag: assert property (err_locked_o |-> status_o[1])
        else $error("locked flag wrong");
endmodule : flash_host_ctrl_properties

// *** verification/flash_model.sv ***
// Behavioural flash device: command decoder, sequencer and status
`timescale 1ns/1ps
module flash_model
    import flash_host_pkg::*;
#(
    parameter int BUSY_CYC = 20
)
(
    input wire logic clk_i,
    input wire logic [1:0] fault_i,
    input wire logic [21:0] addr_i,
    input wire logic [15:0] d_i,
    input wire strobe_type pins_i,
    output logic [15:0] q_o
);
    // Fault 1 fails the operation, 2 flags low supply, 3 never ends
    logic [15:0] mem [16];
    logic [15:0] out = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [15:0] wd = 16'h0000;
    logic [21:0] wa = 22'h000000;
    logic [7:0] sr = 8'h00;
    logic [7:0] setup = 8'h00;
    logic stat = 1'b0;
    logic ers = 1'b0;
    logic psus = 1'b0;
    logic esus = 1'b0;
    logic wpend = 1'b0;
    int busy = 0;
    wire logic rd = pins_i.rst_n && !pins_i.ce_n && !pins_i.oe_n
        && pins_i.we_n;
    wire logic ready = busy == 0 || psus || esus;
    wire logic [7:0] c = wd[7:0];
    // Released bus shows the inverse so a stale value never passes
    // Array data follow the address; status is latched per strobe
    assign q_o = !rd ? ~last : stat ? out : mem[addr_i[3:0]];
    initial
        foreach (mem[i])
            mem[i] = 16'hFFFF;
    always @(posedge clk_i)
        if (rd)
            last = q_o;
    always @(negedge pins_i.oe_n or negedge pins_i.ce_n)
        out = {8'h00, ready, esus, sr[5:3], psus, sr[1], 1'b0};
    task automatic start();
        stat = 1'b1;
        ers = setup == CMD_ERASE_SETUP;
        if (wa[21])
            sr[1] = 1'b1;
        else if (ers && c != CMD_CONFIRM)
            sr[5:4] = 2'h3;
        else if (fault_i == 2'h2)
            sr[3] = 1'b1;
        else if (fault_i == 2'h1)
            sr[ers ? 5 : 4] = 1'b1;
        else
        begin
            busy = (fault_i == 2'h3) ? 1 << 30 : BUSY_CYC;
            if (ers)
                foreach (mem[i])
                    mem[i] = 16'h0000;
            if (ers)
                foreach (mem[i])
                    mem[i] = 16'hFFFF;
            else
                mem[wa[3:0]] = mem[wa[3:0]] & wd;
        end
        setup = 8'h00;
    endtask : start
    // ----------------------------------------
    // Pins are sampled on the bench clock; writes act at release
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (busy > 0 && !psus && !esus)
            busy = busy - 1;
        if (!pins_i.rst_n)
        begin
            busy = 0;
            psus = 1'b0;
            esus = 1'b0;
            setup = 8'h00;
            wpend = 1'b0;
        end
        else if (!pins_i.we_n && !pins_i.ce_n && pins_i.oe_n)
        begin
            wd = d_i;
            wa = addr_i;
            wpend = 1'b1;
        end
        else if (wpend)
        begin
            wpend = 1'b0;
            if (!ready)
            begin
                psus = c == CMD_SUSPEND && !ers;
                esus = c == CMD_SUSPEND && ers;
            end
            else if (setup != 8'h00)
                start();
            else if (c == CMD_PROG_SETUP || c == CMD_PROG_ALT)
                setup = c;
            else if (c == CMD_ERASE_SETUP && !psus && !esus)
                setup = c;
            else if (c == CMD_CONFIRM)
            begin
                psus = 1'b0;
                esus = 1'b0;
            end
            else if (c == CMD_READ_STATUS || c == CMD_READ_ARRAY)
                stat = c == CMD_READ_STATUS;
            else if (c == CMD_CLEAR_STATUS)
                sr = sr & 8'h04;
        end
    end
endmodule : flash_model

// *** verification/test_flash_host_ctrl.sv ***
// Testbench driving the flash host controller against a device model
`timescale 1ns/1ps
module test_flash_host_ctrl;
    import flash_host_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    req_type req_i = '0;
    logic abort_i = 1'b0;
    logic [1:0] fault = 2'h0;
    logic req_ready_o, done_o, dq_oe_o, suspended_o, err_timeout_o;
    logic err_locked_o, err_supply_o, err_program_o, err_erase_o;
    logic err_sequence_o;
    logic [15:0] rdata_o, dq_o, dq_i;
    logic [7:0] status_o;
    logic [21:0] addr_o;
    strobe_type strobe_o;
    int err_count = 0;
    int n_tests = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    // Few polls allowed so the hang case ends quickly
    flash_host_ctrl #(.POLL_MAX(8)) i_flash_host_ctrl (.ref_clk_i,
        .rst_i, .req_valid_i, .req_i, .abort_i, .req_ready_o, .done_o,
        .rdata_o, .status_o, .err_locked_o, .err_supply_o, .err_program_o,
        .err_erase_o, .err_sequence_o, .err_timeout_o, .suspended_o,
        .addr_o, .dq_o, .dq_oe_o, .dq_i, .strobe_o);
    flash_model i_flash_model (.clk_i(ref_clk_i), .fault_i(fault),
        .addr_i(addr_o), .d_i(dq_o), .pins_i(strobe_o), .q_o(dq_i));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_flag(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask : chk_flag
    task automatic run(input op_type op, input logic [21:0] a,
        input logic [15:0] d, input logic [1:0] f);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 100)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n == 100)
            err_count++;
        @(posedge ref_clk_i);
        fault <= f;
        req_i <= '{op, a, d};
        req_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 20000)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n == 20000)
            err_count++;
    endtask : run
    task automatic tstat(input op_type op, input logic [21:0] a,
        input logic [15:0] d, input logic [1:0] f, input logic [7:0] e);
        run(op, a, d, f);
        chk({8'h00, status_o}, {8'h00, e});
    endtask : tstat
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    initial
    begin
        #1500000;
        err_count++;
        final_report();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        tstat(OP_PROGRAM, 22'h000003, 16'hA5A5, 2'h0, 8'h80);
        tstat(OP_PROGRAM, 22'h000004, 16'h1234, 2'h0, 8'h80);
        run(OP_READ, 22'h000003, 16'h0000, 2'h0);
        chk(rdata_o, 16'hA5A5);
        $display("test program done");
        tstat(OP_ERASE, 22'h000005, 16'h0000, 2'h0, 8'h80);
        run(OP_READ, 22'h000004, 16'h0000, 2'h0);
        chk(rdata_o, 16'hFFFF);
        $display("test erase done");
        tstat(OP_PROGRAM, 22'h200003, 16'h0000, 2'h0, 8'h82);
        chk_flag(err_locked_o, 1'b1);
        run(OP_CLEAR, 22'h000000, 16'h0000, 2'h0);
        tstat(OP_STATUS, 22'h000000, 16'h0000, 2'h0, 8'h80);
        $display("test locked done");
        tstat(OP_ERASE, 22'h000005, 16'h0000, 2'h1, 8'hA0);
        chk_flag(err_erase_o, 1'b1);
        chk_flag(err_sequence_o, 1'b0);
        run(OP_CLEAR, 22'h000000, 16'h0000, 2'h0);
        tstat(OP_PROGRAM, 22'h000004, 16'h00FF, 2'h1, 8'h90);
        chk_flag(err_program_o, 1'b1);
        tstat(OP_PROGRAM, 22'h000004, 16'h00FF, 2'h0, 8'h90);
        run(OP_READ, 22'h000004, 16'h0000, 2'h0);
        chk(rdata_o, 16'h00FF);
        run(OP_CLEAR, 22'h000000, 16'h0000, 2'h0);
        $display("test failures done");
        tstat(OP_ERASE, 22'h000005, 16'h0000, 2'h2, 8'h88);
        chk_flag(err_supply_o, 1'b1);
        run(OP_CLEAR, 22'h000000, 16'h0000, 2'h0);
        tstat(OP_STATUS, 22'h000000, 16'h0000, 2'h0, 8'h80);
        $display("test supply done");
        run(OP_PROGRAM, 22'h000006, 16'h0000, 2'h3);
        chk_flag(err_timeout_o, 1'b1);
        tstat(OP_STATUS, 22'h000000, 16'h0000, 2'h0, 8'h80);
        $display("test timeout done");
        tstat(OP_SUSPEND, 22'h000000, 16'h0000, 2'h0, 8'h80);
        chk_flag(suspended_o, 1'b0);
        tstat(OP_RESUME, 22'h000000, 16'h0000, 2'h0, 8'h80);
        chk_flag(suspended_o, 1'b0);
        $display("test suspend done");
        fork
            run(OP_PROGRAM, 22'h000007, 16'h0000, 2'h3);
            begin
                repeat (30) @(posedge ref_clk_i);
                abort_i <= 1'b1;
                @(posedge ref_clk_i);
                abort_i <= 1'b0;
            end
        join
        chk_flag(err_timeout_o, 1'b0);
        tstat(OP_STATUS, 22'h000000, 16'h0000, 2'h0, 8'h80);
        $display("test abort done");
        final_report();
    end
endmodule : test_flash_host_ctrl
bind flash_host_ctrl flash_host_ctrl_properties #(.HOLD_CYC(HOLD_CYC))
    i_flash_host_ctrl_properties (.ref_clk_i, .rst_i, .done_o, .status_o,
    .err_locked_o, .err_program_o, .err_erase_o, .err_sequence_o,
    .suspended_o, .dq_oe_o, .strobe_o);
